// ===== rtl/wdwk_pkg.sv
// Constants, types and helpers shared by the watchdog and wake-up block
// Functional notes
// - Wake from power-down on four sources
// - Reset wake gives full reset; overflow gives watchdog wake
// - Power-down flag: clear on power-up/dog clear, set on halt
// - Time-out sets flag; sleep wake resets only PC/SP
// - Masked port A falling edge wakes, resumes after halt
// - Disabled irq or full stack: resume after halt
// - Enabled irq with stack room: vector to handler
// - Request already pending before halt cannot wake
// - Wake delay: reset delay+128, else 2 or 128
// - Dog instructions are no-ops while dog is off
// - Dog on if option set or key not 1010B
// - Key powers up disabled; software should write 0101B
// - Dog clock: crystal, system/4 or RC; system/4 halts
// - Time-out is 2^(8+select) dog clock periods
// - Period select resets to all ones, longest
// - Normal-mode time-out resets device and sets flag
// - Counter clears on reset pin, clear sequence, halt
// - Single or paired clear scheme by configuration
// - Paired scheme: only alternation clears counter
// - Upper five period bits read as zero
// - Halt enters sleep, sets power-down, clears time-out
// - Halt clears dog; low-speed sources keep counting
// - Time-out in sleep leaves both flags set
package wdwk_pkg;
   localparam logic [7:0]  ADDR_PERIOD      = 8'h00;
   localparam logic [7:0]  ADDR_CTRL_ONE    = 8'h01;
   localparam logic [7:0]  ADDR_CTRL_ZERO   = 8'h02;
   localparam logic [7:0]  ADDR_STATUS      = 8'h03;
   localparam logic [7:0]  ADDR_WAKE_MASK   = 8'h04;
   localparam int          SEL_W            = 3;
   localparam int          KEY_W            = 4;
   localparam int          CNT_W            = 16;
   localparam int          DLY_W            = 24;
   localparam int          PERIOD_BASE_EXP  = 8;
   localparam logic [2:0]  PERIOD_RESET     = 3'h7;
   localparam logic [3:0]  KEY_DISABLE      = 4'ha;
   localparam int          STATUS_TO_BIT    = 0;
   localparam int          STATUS_PDF_BIT   = 1;
   localparam int          LOWPOWER_BIT     = 0;
   localparam logic [1:0]  SRC_LXT          = 2'h0;
   localparam logic [1:0]  SRC_SYSDIV       = 2'h1;
   localparam logic [1:0]  SRC_LOW_SPEED_RC_OSC         = 2'h2;
   localparam logic [1:0]  SYSDIV_LAST      = 2'h3;
   localparam int          CLK_PERIOD_NS    = 10;
   localparam int          RESET_DELAY_MS   = 100;
   localparam int          RESET_DELAY_CYC  = RESET_DELAY_MS * 1000000 / CLK_PERIOD_NS;
   localparam int          SHORT_STARTUP    = 2;
   localparam int          LONG_STARTUP     = 128;

   typedef enum logic [3:0] {
      ST_RUN    = 4'b0001,
      ST_SLEEP  = 4'b0010,
      ST_WAKE   = 4'b0100,
      ST_EXTRST = 4'b1000
   } wdwk_state_e;

   typedef enum logic [1:0] {
      ACT_RESUME  = 2'h0,
      ACT_VECTOR  = 2'h1,
      ACT_DOGWAKE = 2'h2
   } wdwk_act_e;

   typedef enum logic [1:0] {
      PAIR_NONE   = 2'h0,
      PAIR_FIRST  = 2'h1,
      PAIR_SECOND = 2'h2
   } wdwk_pair_e;

   function automatic logic [CNT_W-1:0] wdwk_limit(input logic [SEL_W-1:0] sel);
      wdwk_limit = (CNT_W'(1) << (PERIOD_BASE_EXP + int'(sel))) - CNT_W'(1);
   endfunction
endpackage

// ===== rtl/wdwk_counter.sv
// Watchdog counter with selectable time-out limit
`timescale 1ns/10ps
module wdwk_counter (
   input  wire logic                         clk,
   input  wire logic                         rst,
   input  wire logic                         tick,
   input  wire logic                         clear,
   input  wire logic [wdwk_pkg::SEL_W-1:0]   sel,
   output logic      [wdwk_pkg::CNT_W-1:0]   count,
   output logic                              overflow
);
   logic [wdwk_pkg::CNT_W-1:0] count_q;
   logic [wdwk_pkg::CNT_W-1:0] count_d;

   assign overflow = tick && !clear && (count_q == wdwk_pkg::wdwk_limit(sel));
   assign count    = count_q;

   always_comb begin
      count_d = count_q;
      if (clear || overflow) begin
         count_d = '0;
      end else if (tick) begin
         count_d = count_q + wdwk_pkg::CNT_W'(1);
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         count_q <= '0;
      end else begin
         count_q <= count_d;
      end
   end
endmodule

// ===== rtl/wdwk_top.sv
// Watchdog timer with power-down and wake-up control
//
// The register addresses and the address-and-strobe port were left to the implementer.
`timescale 1ns/10ps
module wdwk_top #(
   parameter int RESET_DELAY_CYC = wdwk_pkg::RESET_DELAY_CYC
) (
   input  wire logic         clk,
   input  wire logic         rst,
   input  wire logic         cfgDogEnable,
   input  wire logic [1:0]   cfgClkSrc,
   input  wire logic         cfgPairedClear,
   input  wire logic         cfgCrystalOsc,
   input  wire logic         lxtRunning,
   input  wire logic         lxtTick,
   input  wire logic         lircTick,
   input  wire logic         extResetN,
   input  wire logic         instHalt,
   input  wire logic         instClearSingle,
   input  wire logic         instClearFirst,
   input  wire logic         instClearSecond,
   input  wire logic [7:0]   portAPins,
   input  wire logic [3:0]   irqReq,
   input  wire logic [3:0]   irqEnable,
   input  wire logic         stackFull,
   input  wire logic [7:0]   regAddr,
   input  wire logic [7:0]   regWdata,
   input  wire logic         regWrite,
   input  wire logic         regRead,
   output logic      [7:0]   regRdata,
   output logic              timeoutFlag,
   output logic              powerdownFlag,
   output logic              idleMode,
   output logic              sleepMode,
   output logic              cpuHold,
   output logic              resumePulse,
   output logic              vectorPulse,
   output logic      [1:0]   vectorIndex,
   output logic              dogResetPulse,
   output logic              dogWakePulse,
   output logic              fullResetPulse,
   output logic              crystalLowPower
);
   // Register group
   logic [wdwk_pkg::SEL_W-1:0] period_q;
   logic [wdwk_pkg::SEL_W-1:0] period_d;
   logic [wdwk_pkg::KEY_W-1:0] key_q;
   logic [wdwk_pkg::KEY_W-1:0] key_d;
   logic                       lowPower_q;
   logic                       lowPower_d;
   logic [7:0]                 wakeMask_q;
   logic [7:0]                 wakeMask_d;
   logic [7:0]                 rdata_q;
   logic [7:0]                 rdata_d;

   // Control group
   wdwk_pkg::wdwk_state_e      state_q;
   wdwk_pkg::wdwk_state_e      state_d;
   wdwk_pkg::wdwk_act_e        act_q;
   wdwk_pkg::wdwk_act_e        act_d;
   wdwk_pkg::wdwk_pair_e       pair_q;
   wdwk_pkg::wdwk_pair_e       pair_d;
   logic [wdwk_pkg::DLY_W-1:0] dly_q;
   logic [wdwk_pkg::DLY_W-1:0] dly_d;
   logic                       to_q;
   logic                       to_d;
   logic                       pdf_q;
   logic                       pdf_d;
   logic                       lxtAtHalt_q;
   logic                       lxtAtHalt_d;
   logic [3:0]                 irqArm_q;
   logic [3:0]                 irqArm_d;
   logic [7:0]                 pinsPrev_q;
   logic [1:0]                 sysDiv_q;
   logic [1:0]                 sysDiv_d;
   logic                       resume_q;
   logic                       resume_d;
   logic                       vector_q;
   logic                       vector_d;
   logic [1:0]                 vecIdx_q;
   logic [1:0]                 vecIdx_d;
   logic                       dogRst_q;
   logic                       dogRst_d;
   logic                       dogWake_q;
   logic                       dogWake_d;
   logic                       fullRst_q;
   logic                       fullRst_d;

   logic                          dogOn;
   logic                          dogTick;
   logic                          dogClear;
   logic                          swClear;
   logic                          overflow;
   logic [wdwk_pkg::CNT_W-1:0]    dogCount;
   logic                          inPowerDown;
   logic [7:0]                    portFall;
   logic [3:0]                    irqWake;
   logic [1:0]                    irqIdx;
   logic [wdwk_pkg::DLY_W-1:0]    wakeDelay;
   logic [wdwk_pkg::DLY_W-1:0]    resetDelay;

   function automatic logic [1:0] lowestSet(input logic [3:0] v);
      lowestSet = 2'h0;
      for (int i = 3; i >= 0; i--) begin
         if (v[i]) begin
            lowestSet = 2'(i);
         end
      end
   endfunction

   // Watchdog enable, clock source and clearing
   assign dogOn       = cfgDogEnable || (key_q != wdwk_pkg::KEY_DISABLE);
   assign inPowerDown = (state_q == wdwk_pkg::ST_SLEEP);

   always_comb begin
      sysDiv_d = sysDiv_q + 2'h1;
      dogTick  = 1'b0;
      case (cfgClkSrc)
         wdwk_pkg::SRC_LXT:    dogTick = lxtTick;
         // System clock stops in power-down, so this source freezes there
         wdwk_pkg::SRC_SYSDIV: dogTick = !inPowerDown && (sysDiv_q == wdwk_pkg::SYSDIV_LAST);
         wdwk_pkg::SRC_LOW_SPEED_RC_OSC:   dogTick = lircTick;
         default:              dogTick = 1'b0;
      endcase
      dogTick = dogTick && dogOn;
   end

   // Paired scheme remembers which half was seen last
   always_comb begin
      pair_d  = pair_q;
      swClear = 1'b0;
      if (dogOn) begin
         if (!cfgPairedClear) begin
            swClear = instClearSingle;
         end else if (instClearFirst) begin
            swClear = (pair_q == wdwk_pkg::PAIR_SECOND);
            pair_d  = swClear ? wdwk_pkg::PAIR_NONE : wdwk_pkg::PAIR_FIRST;
         end else if (instClearSecond) begin
            swClear = (pair_q == wdwk_pkg::PAIR_FIRST);
            pair_d  = swClear ? wdwk_pkg::PAIR_NONE : wdwk_pkg::PAIR_SECOND;
         end
      end
      if (!extResetN) begin
         pair_d = wdwk_pkg::PAIR_NONE;
      end
   end

   assign dogClear = !extResetN || swClear ||
                     (instHalt && dogOn && state_q == wdwk_pkg::ST_RUN);

   wdwk_counter u_counter (
      .clk      (clk),
      .rst      (rst),
      .tick     (dogTick),
      .clear    (dogClear),
      .sel      (period_q),
      .count    (dogCount),
      .overflow (overflow)
   );

   // Wake-up sources
   assign portFall   = pinsPrev_q & ~portAPins & wakeMask_q;
   assign irqWake    = irqReq & irqArm_q;
   assign irqIdx     = lowestSet(irqWake);
   assign wakeDelay  = cfgCrystalOsc ? wdwk_pkg::DLY_W'(wdwk_pkg::LONG_STARTUP - 1)
                                     : wdwk_pkg::DLY_W'(wdwk_pkg::SHORT_STARTUP - 1);
   assign resetDelay = wdwk_pkg::DLY_W'(RESET_DELAY_CYC + wdwk_pkg::LONG_STARTUP - 1);

   always_comb begin
      state_d     = state_q;
      act_d       = act_q;
      dly_d       = dly_q;
      to_d        = to_q;
      pdf_d       = pdf_q;
      lxtAtHalt_d = lxtAtHalt_q;
      irqArm_d    = irqArm_q;
      resume_d    = 1'b0;
      vector_d    = 1'b0;
      vecIdx_d    = vecIdx_q;
      dogRst_d    = 1'b0;
      dogWake_d   = 1'b0;
      fullRst_d   = 1'b0;
      if (swClear) begin
         pdf_d = 1'b0;
      end
      case (state_q)
         wdwk_pkg::ST_RUN: begin
            if (instHalt) begin
               state_d     = wdwk_pkg::ST_SLEEP;
               pdf_d       = 1'b1;
               to_d        = 1'b0;
               lxtAtHalt_d = lxtRunning;
               irqArm_d    = ~irqReq;
            end else if (overflow) begin
               dogRst_d = 1'b1;
               to_d     = 1'b1;
            end
         end
         wdwk_pkg::ST_SLEEP: begin
            // Priority: overflow, then interrupts, then port pins
            if (overflow) begin
               state_d = wdwk_pkg::ST_WAKE;
               act_d   = wdwk_pkg::ACT_DOGWAKE;
               to_d    = 1'b1;
               dly_d   = wakeDelay;
            end else if (irqWake != 4'h0) begin
               state_d  = wdwk_pkg::ST_WAKE;
               vecIdx_d = irqIdx;
               dly_d    = wakeDelay;
               if (irqEnable[irqIdx] && !stackFull) begin
                  act_d = wdwk_pkg::ACT_VECTOR;
               end else begin
                  act_d = wdwk_pkg::ACT_RESUME;
               end
            end else if (portFall != 8'h00) begin
               state_d = wdwk_pkg::ST_WAKE;
               act_d   = wdwk_pkg::ACT_RESUME;
               dly_d   = wakeDelay;
            end
         end
         wdwk_pkg::ST_WAKE: begin
            if (overflow) begin
               dogRst_d = 1'b1;
               to_d     = 1'b1;
            end
            if (dly_q != '0) begin
               dly_d = dly_q - wdwk_pkg::DLY_W'(1);
            end else begin
               state_d = wdwk_pkg::ST_RUN;
               case (act_q)
                  wdwk_pkg::ACT_VECTOR:  vector_d  = 1'b1;
                  wdwk_pkg::ACT_DOGWAKE: dogWake_d = 1'b1;
                  default:               resume_d  = 1'b1;
               endcase
            end
         end
         wdwk_pkg::ST_EXTRST: begin
            if (dly_q != '0) begin
               dly_d = dly_q - wdwk_pkg::DLY_W'(1);
            end else begin
               state_d   = wdwk_pkg::ST_RUN;
               fullRst_d = 1'b1;
            end
         end
         default: begin
            state_d = wdwk_pkg::ST_RUN;
         end
      endcase
      // Reset pin overrides state and delay; flags keep their values unless a halt or clear lands in the same cycle
      if (!extResetN) begin
         state_d = wdwk_pkg::ST_EXTRST;
         dly_d   = resetDelay;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         state_q     <= wdwk_pkg::ST_RUN;
         act_q       <= wdwk_pkg::ACT_RESUME;
         pair_q      <= wdwk_pkg::PAIR_NONE;
         dly_q       <= '0;
         to_q        <= 1'b0;
         pdf_q       <= 1'b0;
         lxtAtHalt_q <= 1'b0;
         irqArm_q    <= 4'h0;
         pinsPrev_q  <= 8'h00;
         sysDiv_q    <= 2'h0;
         resume_q    <= 1'b0;
         vector_q    <= 1'b0;
         vecIdx_q    <= 2'h0;
         dogRst_q    <= 1'b0;
         dogWake_q   <= 1'b0;
         fullRst_q   <= 1'b0;
      end else begin
         state_q     <= state_d;
         act_q       <= act_d;
         pair_q      <= pair_d;
         dly_q       <= dly_d;
         to_q        <= to_d;
         pdf_q       <= pdf_d;
         lxtAtHalt_q <= lxtAtHalt_d;
         irqArm_q    <= irqArm_d;
         pinsPrev_q  <= portAPins;
         sysDiv_q    <= sysDiv_d;
         resume_q    <= resume_d;
         vector_q    <= vector_d;
         vecIdx_q    <= vecIdx_d;
         dogRst_q    <= dogRst_d;
         dogWake_q   <= dogWake_d;
         fullRst_q   <= fullRst_d;
      end
   end

   // Register port
   always_comb begin
      period_d   = period_q;
      key_d      = key_q;
      lowPower_d = lowPower_q;
      wakeMask_d = wakeMask_q;
      rdata_d    = 8'h00;
      if (regWrite) begin
         case (regAddr)
            wdwk_pkg::ADDR_PERIOD:    period_d   = regWdata[wdwk_pkg::SEL_W-1:0];
            wdwk_pkg::ADDR_CTRL_ONE:  key_d      = regWdata[wdwk_pkg::KEY_W-1:0];
            wdwk_pkg::ADDR_CTRL_ZERO: lowPower_d = regWdata[wdwk_pkg::LOWPOWER_BIT];
            wdwk_pkg::ADDR_WAKE_MASK: wakeMask_d = regWdata;
            default:                  period_d   = period_q;
         endcase
      end
      if (regRead) begin
         case (regAddr)
            wdwk_pkg::ADDR_PERIOD:    rdata_d[wdwk_pkg::SEL_W-1:0] = period_q;
            wdwk_pkg::ADDR_CTRL_ONE:  rdata_d[wdwk_pkg::KEY_W-1:0] = key_q;
            wdwk_pkg::ADDR_CTRL_ZERO: rdata_d[wdwk_pkg::LOWPOWER_BIT] = lowPower_q;
            wdwk_pkg::ADDR_STATUS: begin
               rdata_d[wdwk_pkg::STATUS_TO_BIT]  = to_q;
               rdata_d[wdwk_pkg::STATUS_PDF_BIT] = pdf_q;
            end
            wdwk_pkg::ADDR_WAKE_MASK: rdata_d = wakeMask_q;
            default:                  rdata_d = 8'h00;
         endcase
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         period_q   <= wdwk_pkg::PERIOD_RESET;
         key_q      <= wdwk_pkg::KEY_DISABLE;
         lowPower_q <= 1'b0;
         wakeMask_q <= 8'h00;
         rdata_q    <= 8'h00;
      end else begin
         period_q   <= period_d;
         key_q      <= key_d;
         lowPower_q <= lowPower_d;
         wakeMask_q <= wakeMask_d;
         rdata_q    <= rdata_d;
      end
   end

   assign regRdata        = rdata_q;
   assign timeoutFlag     = to_q;
   assign powerdownFlag   = pdf_q;
   assign idleMode        = inPowerDown && lxtAtHalt_q;
   assign sleepMode       = inPowerDown && !lxtAtHalt_q;
   assign cpuHold         = (state_q != wdwk_pkg::ST_RUN);
   assign resumePulse     = resume_q;
   assign vectorPulse     = vector_q;
   assign vectorIndex     = vecIdx_q;
   assign dogResetPulse   = dogRst_q;
   assign dogWakePulse    = dogWake_q;
   assign fullResetPulse  = fullRst_q;
   assign crystalLowPower = lowPower_q;

   // Checks
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   halt_enters_sleep_a: assert property (
      state_q == wdwk_pkg::ST_RUN && instHalt && extResetN
      |=> inPowerDown && powerdownFlag && !timeoutFlag)
      else $error("halt did not enter power-down with correct flags");

   dog_off_quiet_a: assert property (
      !cfgDogEnable && key_q == wdwk_pkg::KEY_DISABLE |-> !dogTick && !swClear)
      else $error("watchdog active while disabled");

   normal_timeout_a: assert property (
      state_q == wdwk_pkg::ST_RUN && !instHalt && overflow && extResetN
      |=> dogResetPulse && timeoutFlag)
      else $error("normal time-out did not reset and flag");

   sleep_timeout_a: assert property (
      inPowerDown && overflow && extResetN
      |=> timeoutFlag && powerdownFlag && state_q == wdwk_pkg::ST_WAKE)
      else $error("sleep time-out flags wrong");

   port_wake_short_a: assert property (
      inPowerDown && !overflow && irqWake == 4'h0 && portFall != 8'h00 && extResetN
      && !cfgCrystalOsc ##1 extResetN [*2]
      |=> resumePulse)
      else $error("port wake not resumed after short delay");

   dog_wake_long_a: assert property (
      inPowerDown && overflow && extResetN && cfgCrystalOsc
      |-> ##128 !dogWakePulse ##1 dogWakePulse || !extResetN)
      else $error("watchdog wake delay wrong");

   armed_irq_only_a: assert property (
      inPowerDown && extResetN && !overflow && portFall == 8'h00 && irqWake == 4'h0
      |=> inPowerDown)
      else $error("woke without a fresh source");

   paired_repeat_a: assert property (
      cfgPairedClear && pair_q == wdwk_pkg::PAIR_FIRST && instClearFirst
      |-> !swClear)
      else $error("repeated first clear cleared the counter");

   period_upper_a: assert property (
      regRead && regAddr == wdwk_pkg::ADDR_PERIOD |=> regRdata[7:3] == 5'h00)
      else $error("period select upper bits not zero");

   halt_clears_dog_a: assert property (
      state_q == wdwk_pkg::ST_RUN && instHalt && dogOn |=> dogCount == '0)
      else $error("halt did not clear the watchdog counter");
endmodule

// ===== tb/wdwk_top_tb_top.sv
// Self-checking bench for the watchdog and wake-up block
`timescale 1ns/10ps
module wdwk_top_tb_top;
   logic        clk = 1'b0;
   logic        rst = 1'b1;
   logic        cfgDogEnable = 1'b0;
   logic [1:0]  cfgClkSrc = wdwk_pkg::SRC_SYSDIV;
   logic        cfgPairedClear = 1'b0;
   logic        cfgCrystalOsc = 1'b0;
   logic        lxtRunning = 1'b0;
   logic        tick = 1'b0;
   logic [1:0]  tickCnt = 2'h0;
   logic        extResetN = 1'b1;
   logic [3:0]  ins = 4'h0;
   logic [7:0]  portAPins = 8'hff;
   logic [3:0]  irqReq = 4'h0;
   logic [3:0]  irqEnable = 4'h0;
   logic        stackFull = 1'b0;
   logic [7:0]  regAddr = 8'h00;
   logic [7:0]  regWdata = 8'h00;
   logic        regWrite = 1'b0;
   logic        regRead = 1'b0;
   logic        rdSeen = 1'b0;
   logic [7:0]  regRdata;
   logic        timeoutFlag, powerdownFlag, idleMode, sleepMode, cpuHold, resumePulse;
   logic        vectorPulse, dogResetPulse, dogWakePulse, fullResetPulse, crystalLowPower;
   logic [1:0]  vectorIndex;
   logic [6:0]  evNow;
   logic [7:0]  rdQ[$];
   logic [6:0]  evQ[$];
   int          nTests = 0;
   int          nMismatch = 0;
   int          seed;
   logic [31:0] rnd;
   // Event codes: full reset, dog wake, dog reset, vector, resume, vector index
   localparam logic [6:0] EV_RES  = 7'h04;
   localparam logic [6:0] EV_VEC1 = 7'h09;
   localparam logic [6:0] EV_DOG  = 7'h10;
   localparam logic [6:0] EV_WAKE = 7'h20;
   localparam logic [6:0] EV_FULL = 7'h40;

   wdwk_top #(.RESET_DELAY_CYC(20)) wdwk_top_inst (
      .clk(clk), .rst(rst), .cfgDogEnable(cfgDogEnable), .cfgClkSrc(cfgClkSrc),
      .cfgPairedClear(cfgPairedClear), .cfgCrystalOsc(cfgCrystalOsc),
      .lxtRunning(lxtRunning), .lxtTick(tick), .lircTick(tick), .extResetN(extResetN),
      .instHalt(ins[0]), .instClearSingle(ins[1]), .instClearFirst(ins[2]),
      .instClearSecond(ins[3]), .portAPins(portAPins), .irqReq(irqReq),
      .irqEnable(irqEnable), .stackFull(stackFull), .regAddr(regAddr),
      .regWdata(regWdata), .regWrite(regWrite), .regRead(regRead), .regRdata(regRdata),
      .timeoutFlag(timeoutFlag), .powerdownFlag(powerdownFlag), .idleMode(idleMode),
      .sleepMode(sleepMode), .cpuHold(cpuHold), .resumePulse(resumePulse),
      .vectorPulse(vectorPulse), .vectorIndex(vectorIndex), .dogResetPulse(dogResetPulse),
      .dogWakePulse(dogWakePulse), .fullResetPulse(fullResetPulse),
      .crystalLowPower(crystalLowPower));

   assign evNow = {fullResetPulse, dogWakePulse, dogResetPulse, vectorPulse, resumePulse,
                   vectorPulse ? vectorIndex : 2'h0};

   always #5 clk = ~clk;

   // Slow dog clock: one tick every fourth cycle, free running
   always @(posedge clk) begin
      tickCnt <= tickCnt + 2'h1;
      tick    <= (tickCnt == 2'h3);
      rdSeen  <= regRead;
   end

   task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
      nTests++;
      if (g !== e) begin
         nMismatch++;
         $display("[ERR] %s expected %h seen %h", nm, e, g);
      end
   endtask

   // Any pulse with no note queued is a mismatch, so quiet stretches are checked too
   always @(negedge clk) begin
      if (!rst && rdSeen) begin
         if (rdQ.size() == 0)
            chk("readQueue", 8'h00, 8'hff);
         else
            chk("regRdata", rdQ.pop_front(), regRdata);
      end
      if (!rst && evNow !== 7'h00) begin
         if (evQ.size() == 0)
            chk("unexpectedPulse", 8'h00, {1'b0, evNow});
         else
            chk("pulse", {1'b0, evQ.pop_front()}, {1'b0, evNow});
      end
   end

   task automatic print_verdict();
      $display("Checks %0d mismatches %0d", nTests, nMismatch);
      if (nMismatch == 0 && nTests > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      regAddr  <= a;
      regWdata <= d;
      regWrite <= 1'b1;
      @(posedge clk);
      regWrite <= 1'b0;
   endtask

   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      rdQ.push_back(e);
      @(posedge clk);
      regAddr <= a;
      regRead <= 1'b1;
      @(posedge clk);
      regRead <= 1'b0;
   endtask

   task automatic instr(input logic [3:0] v);
      @(posedge clk);
      ins <= v;
      @(posedge clk);
      ins <= 4'h0;
   endtask

   // Bounded wait for a pulse; its delay must fall inside lo..hi cycles
   task automatic waitEv(input logic [6:0] e, input int lo, input int hi);
      int n;
      n = 0;
      evQ.push_back(e);
      do begin
         @(negedge clk);
         n++;
      end while (evNow === 7'h00 && n < hi);
      nTests++;
      if (evNow === 7'h00 || n < lo) begin
         nMismatch++;
         $display("[ERR] pulseDelay expected %0d..%0d seen %0d", lo, hi, n);
         if (evNow === 7'h00)
            print_verdict();
      end
   endtask

   initial begin
      seed = 32'hc809;
      repeat (8) @(posedge clk);
      rst <= 1'b0;
      rd(wdwk_pkg::ADDR_PERIOD, 8'h07);
      rd(wdwk_pkg::ADDR_STATUS, 8'h00);
      rd(8'h1f, 8'h00);
      for (int i = 0; i < 4; i++) begin
         rnd = $random(seed);
         wr(wdwk_pkg::ADDR_PERIOD, rnd[7:0]);
         rd(wdwk_pkg::ADDR_PERIOD, {5'h00, rnd[2:0]});
      end
      wr(wdwk_pkg::ADDR_PERIOD, 8'h00);
      wr(wdwk_pkg::ADDR_CTRL_ZERO, 8'h01);
      @(negedge clk);
      chk("crystalLowPower", 8'h01, {7'h00, crystalLowPower});
      rd(wdwk_pkg::ADDR_CTRL_ZERO, 8'h01);
      repeat (1500) @(posedge clk);
      cfgDogEnable <= 1'b1;
      instr(4'h2);
      waitEv(EV_DOG, 1016, 1032);
      rd(wdwk_pkg::ADDR_STATUS, 8'h01);
      wr(wdwk_pkg::ADDR_CTRL_ONE, 8'h05);
      cfgDogEnable <= 1'b0;
      repeat (3) begin
         repeat (700) @(posedge clk);
         instr(4'h2);
      end
      waitEv(EV_DOG, 1016, 1032);
      // Paired scheme: a repeated first clear must leave the count running
      cfgPairedClear <= 1'b1;
      instr(4'h4);
      repeat (600) @(posedge clk);
      instr(4'h4);
      waitEv(EV_DOG, 380, 440);
      instr(4'h4);
      repeat (600) @(posedge clk);
      instr(4'h8);
      waitEv(EV_DOG, 1016, 1032);
      cfgPairedClear <= 1'b0;
      wr(wdwk_pkg::ADDR_WAKE_MASK, 8'h01);
      instr(4'h1);
      @(negedge clk);
      chk("sleepMode", 8'h01, {7'h00, sleepMode});
      chk("cpuHold", 8'h01, {7'h00, cpuHold});
      rd(wdwk_pkg::ADDR_STATUS, 8'h02);
      for (int i = 0; i < 1500; i++) begin
         @(posedge clk);
         rnd = $random(seed);
         portAPins <= {rnd[7:1], 1'b1};
      end
      @(posedge clk);
      portAPins <= 8'hfe;
      waitEv(EV_RES, 2, 6);
      portAPins <= 8'hff;
      wr(wdwk_pkg::ADDR_CTRL_ONE, 8'h0a);
      instr(4'h2);
      rd(wdwk_pkg::ADDR_STATUS, 8'h02);
      wr(wdwk_pkg::ADDR_CTRL_ONE, 8'h05);
      instr(4'h2);
      rd(wdwk_pkg::ADDR_STATUS, 8'h00);
      cfgCrystalOsc <= 1'b1;
      lxtRunning    <= 1'b1;
      irqEnable     <= 4'h2;
      instr(4'h1);
      @(negedge clk);
      chk("idleMode", 8'h01, {7'h00, idleMode});
      @(posedge clk);
      irqReq <= 4'h2;
      waitEv(EV_VEC1, 128, 133);
      irqReq    <= 4'h0;
      stackFull <= 1'b1;
      instr(4'h1);
      @(posedge clk);
      irqReq <= 4'h2;
      waitEv(EV_RES, 128, 133);
      stackFull <= 1'b0;
      instr(4'h1);
      // Request already set at halt: a later new request must not wake
      repeat (100) @(posedge clk);
      irqReq <= 4'h0;
      repeat (100) @(posedge clk);
      irqReq <= 4'h2;
      repeat (100) @(posedge clk);
      portAPins <= 8'hfe;
      waitEv(EV_RES, 128, 133);
      portAPins <= 8'hff;
      irqReq    <= 4'h0;
      cfgClkSrc <= wdwk_pkg::SRC_LOW_SPEED_RC_OSC;
      instr(4'h1);
      waitEv(EV_WAKE, 1140, 1170);
      rd(wdwk_pkg::ADDR_STATUS, 8'h03);
      cfgClkSrc <= wdwk_pkg::SRC_SYSDIV;
      instr(4'h1);
      @(posedge clk);
      extResetN <= 1'b0;
      repeat (3) @(posedge clk);
      extResetN <= 1'b1;
      waitEv(EV_FULL, 147, 154);
      rd(wdwk_pkg::ADDR_STATUS, 8'h02);
      repeat (4) @(posedge clk);
      print_verdict();
   end
endmodule
